// file: core/ccp_pkg.sv
// Constants and carrier types for the console panel sequencer.
// Assumes one 10 MHz processor clock and a power-on reset.
package ccp_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 10;
	localparam int SW_SETTLE_US = 5000;
	localparam int SW_SETTLE_CYC = SW_SETTLE_US * CLK_MHZ;
	localparam int BLINK_HALF_MS = 250;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
	localparam int CNT_W = 22;
	localparam int WORD_W = 16;

	// ----------------------------------------------------------------
	// Switch vector layout
	// ----------------------------------------------------------------
	localparam int SW_SENSE = 0;
	localparam int SW_ENTRY = 3;
	localparam int SW_VCLR = 19;
	localparam int SW_SHOW = 20;
	localparam int SW_DEP = 21;
	localparam int SW_START = 22;
	localparam int SW_LOAD = 23;
	localparam int SW_MODE = 24;
	localparam int SW_VIEW = 25;
	localparam int SW_FSET = 30;
	localparam int SW_FCLR = 34;
	localparam int SW_FINC = 35;
	localparam int SW_N = 36;

	// ----------------------------------------------------------------
	// Status word, register file, reset values
	// ----------------------------------------------------------------
	localparam int STAT_OVF_BIT = 8;
	localparam logic [3:0] SEL_ZEROS = 4'hb;
	localparam logic [3:0] SEL_ONES = 4'hc;
	localparam logic [3:0] SEL_RST = 4'h0;
	localparam logic [15:0] DISP_RST = 16'h0000;
	localparam logic [2:0] FLAG_RST = 3'h0;

	// ----------------------------------------------------------------
	// Loader selection codes and images
	// ----------------------------------------------------------------
	localparam logic [15:0] BOOT_TAPE_LO = 16'h0000;
	localparam logic [15:0] BOOT_TAPE_HI = 16'h0001;
	localparam logic [15:0] BOOT_DISC_A = 16'h0002;
	localparam logic [15:0] BOOT_DISC_B = 16'h0003;
	localparam logic [15:0] TAPE_BASE = 16'h0080;
	localparam logic [5:0] TAPE_LAST = 6'h0f;
	localparam logic [15:0] DISC_A_BASE = 16'h0258;
	localparam logic [5:0] DISC_A_LAST = 6'h1f;
	localparam logic [15:0] DISC_B_BASE = 16'h0258;
	localparam logic [5:0] DISC_B_LAST = 6'h1f;

	// Display selection, one-hot
	typedef enum logic [4:0] {
		VIEW_P = 5'h01,
		VIEW_I = 5'h02,
		VIEW_MEM = 5'h04,
		VIEW_STAT = 5'h08,
		VIEW_REG = 5'h10
	} ccp_view_e;

	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SHOW = 6'h02,
		ST_DEP = 6'h04,
		ST_FETCH = 6'h08,
		ST_EXEC = 6'h10,
		ST_BOOT = 6'h20
	} ccp_state_e;

	// Memory request towards the processor memory control
	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ccp_mem_s;
endpackage

// file: core/ccp_panel.sv
// Console panel sequencer: switches, indicators, manual memory access,
// single stepping and loader copy-in.
// Assumes switches are raw bouncy levels, processor ports share clock.
`timescale 1ns/1ps
module ccp_panel #(
	parameter int SETTLE_CYCLES = ccp_pkg::SW_SETTLE_CYC,
	parameter int BLINK_CYCLES = ccp_pkg::BLINK_HALF_CYC
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [2:0] sense_sw,
	input wire logic [15:0] entry_sw,
	input wire logic view_clear_switch,
	input wire logic show_switch,
	input wire logic deposit_sw,
	input wire logic start_sw,
	input wire logic load_sw,
	input wire logic step_run_sw,
	input wire logic [4:0] view_sw,
	input wire logic [3:0] sel_set_sw,
	input wire logic sel_clear_sw,
	input wire logic sel_incr_sw,
	input wire logic line_recovery,
	input wire logic cpu_halted,
	input wire logic [15:0] status_in,
	input wire logic overflow,
	input wire logic [2:0] flag_test,
	input wire logic flag_test_req,
	output logic flag_test_met,
	input wire logic [15:0] general_register_zero,
	output logic [3:0] gr_sel,
	input wire logic [15:0] gr_rdata,
	output logic gr_we,
	output logic [15:0] gr_wdata,
	output ccp_pkg::ccp_mem_s mem_bus,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	output logic [7:0] prom_addr,
	input wire logic [15:0] prom_rdata,
	output logic exec_req,
	output logic [15:0] exec_instr,
	input wire logic exec_done,
	input wire logic [15:0] exec_next_pc,
	output logic cpu_run,
	output logic [15:0] display_lamps,
	output logic [2:0] sense_lamps,
	output logic [4:0] view_lamps,
	output logic [3:0] sel_lamps,
	output logic run_lamp,
	output logic step_lamp
);
	// ----------------------------------------------------------------
	// Switch conditioning
	// ----------------------------------------------------------------
	logic [ccp_pkg::SW_N-1:0] sw_raw;
	logic [ccp_pkg::SW_N-1:0] press;
	assign sw_raw = {sel_incr_sw, sel_clear_sw, sel_set_sw, view_sw, step_run_sw, load_sw,
		start_sw, deposit_sw, show_switch, view_clear_switch, entry_sw, sense_sw};

	// Two-flop sync, then a settle counter; a press fires on the settled rise
	for (genvar g = 0; g < ccp_pkg::SW_N; g++) begin : g_sw
		logic s1_r, s2_r, stable_r, press_r;
		logic [ccp_pkg::CNT_W-1:0] cnt_r;
		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				s1_r <= 1'b0;
				s2_r <= 1'b0;
				stable_r <= 1'b0;
				press_r <= 1'b0;
				cnt_r <= '0;
			end else begin
				s1_r <= sw_raw[g];
				s2_r <= s1_r;
				press_r <= 1'b0;
				if (s2_r == stable_r) begin
					cnt_r <= '0;
				end else if (cnt_r == ccp_pkg::CNT_W'(SETTLE_CYCLES - 1)) begin
					cnt_r <= '0;
					stable_r <= s2_r;
					press_r <= s2_r;
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
		end
		assign press[g] = press_r;
	end

	// ----------------------------------------------------------------
	// Mode and power-up state
	// ----------------------------------------------------------------
	ccp_pkg::ccp_state_e state_r;
	logic run_r, blink_wait_r, blink_ph_r, rec1_r, rec2_r;
	logic [1:0] init_r;
	logic [ccp_pkg::CNT_W-1:0] blink_cnt_r;
	logic manual_ok, idle, boot_ok, boot_last;
	logic [15:0] boot_base;
	logic [5:0] boot_end, boot_idx_r;
	logic [1:0] boot_code_r;

	assign idle = (state_r == ccp_pkg::ST_IDLE);
	assign manual_ok = (!run_r || cpu_halted) && idle;
	assign boot_ok = general_register_zero[15:2] == 14'h0000;

	// Recovery level is caught by clocks after reset, never by the reset itself
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rec1_r <= 1'b0;
			rec2_r <= 1'b0;
			init_r <= 2'h0;
		end else begin
			rec1_r <= line_recovery;
			rec2_r <= rec1_r;
			if (init_r != 2'h3) begin
				init_r <= init_r + 2'h1;
			end
		end
	end

	// Step/run mode with the pre-boot blinking wait
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			run_r <= 1'b0;
			blink_wait_r <= 1'b0;
		end else if (init_r == 2'h2) begin
			run_r <= rec2_r;
		end else if (press[ccp_pkg::SW_MODE] && state_r != ccp_pkg::ST_BOOT) begin
			run_r <= !run_r;
			blink_wait_r <= !run_r;
		end else if (press[ccp_pkg::SW_LOAD] && blink_wait_r && boot_ok && idle) begin
			blink_wait_r <= 1'b0;
		end
	end

	// Blink divider; only a slow enable, the clock stays single
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			blink_cnt_r <= '0;
			blink_ph_r <= 1'b0;
		end else if (blink_cnt_r == ccp_pkg::CNT_W'(BLINK_CYCLES - 1)) begin
			blink_cnt_r <= '0;
			blink_ph_r <= !blink_ph_r;
		end else begin
			blink_cnt_r <= blink_cnt_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Flags, view selection, register select code
	// ----------------------------------------------------------------
	logic [2:0] sense_r;
	ccp_pkg::ccp_view_e view_r;
	logic [3:0] sel_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sense_r <= ccp_pkg::FLAG_RST;
		end else begin
			sense_r <= sense_r ^ press[ccp_pkg::SW_SENSE +: 3];
		end
	end

	// Flag test for conditional jumps and executes
	assign flag_test_met = flag_test_req && ((sense_r & flag_test) != 3'h0);

	// New view cancels the old one; lowest pressed switch wins
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			view_r <= ccp_pkg::VIEW_P;
		end else if (press[ccp_pkg::SW_VIEW]) begin
			view_r <= ccp_pkg::VIEW_P;
		end else if (press[ccp_pkg::SW_VIEW + 1]) begin
			view_r <= ccp_pkg::VIEW_I;
		end else if (press[ccp_pkg::SW_VIEW + 2]) begin
			view_r <= ccp_pkg::VIEW_MEM;
		end else if (press[ccp_pkg::SW_VIEW + 3]) begin
			view_r <= ccp_pkg::VIEW_STAT;
		end else if (press[ccp_pkg::SW_VIEW + 4]) begin
			view_r <= ccp_pkg::VIEW_REG;
		end
	end

	// Select code: bits set by their switches, clear, or step up
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sel_r <= ccp_pkg::SEL_RST;
		end else if (press[ccp_pkg::SW_FCLR]) begin
			sel_r <= ccp_pkg::SEL_RST;
		end else if (press[ccp_pkg::SW_FINC]) begin
			sel_r <= sel_r + 4'h1;
		end else begin
			sel_r <= sel_r | press[ccp_pkg::SW_FSET +: 4];
		end
	end
	assign gr_sel = sel_r;

	// ----------------------------------------------------------------
	// Display register and register entry
	// ----------------------------------------------------------------
	logic [15:0] disp_r, ir_r, pc_r, status_word, shown, entered;
	logic entry_hit, mem_done;

	assign status_word = {status_in[15:9], overflow, status_in[7:1], 1'b0};
	assign entry_hit = manual_ok && (press[ccp_pkg::SW_VCLR] ||
		(press[ccp_pkg::SW_ENTRY +: 16] != 16'h0000));
	assign mem_done = mem_bus.req && mem_ack;

	// What the indicators currently show
	always_comb begin
		if (view_r == ccp_pkg::VIEW_I) begin
			shown = ir_r;
		end else if (view_r == ccp_pkg::VIEW_P) begin
			shown = pc_r;
		end else if (view_r == ccp_pkg::VIEW_REG) begin
			shown = gr_rdata;
		end else if (view_r == ccp_pkg::VIEW_STAT) begin
			shown = status_word;
		end else begin
			shown = disp_r;
		end
	end

	// Entry only ever sets bits; clearing needs the view-clear switch
	assign entered = press[ccp_pkg::SW_VCLR] ? 16'h0000 :
		(shown | press[ccp_pkg::SW_ENTRY +: 16]);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			disp_r <= ccp_pkg::DISP_RST;
		end else if (state_r == ccp_pkg::ST_SHOW && mem_done) begin
			disp_r <= mem_rdata;
		end else if (entry_hit && view_r != ccp_pkg::VIEW_STAT) begin
			disp_r <= entered;
		end
	end

	// Register file write; the fixed all-zero and all-one slots refuse it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gr_we <= 1'b0;
			gr_wdata <= 16'h0000;
		end else begin
			gr_we <= entry_hit && view_r == ccp_pkg::VIEW_REG &&
				sel_r != ccp_pkg::SEL_ZEROS && sel_r != ccp_pkg::SEL_ONES;
			gr_wdata <= entered;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer: memory examine/deposit, stepping, loader copy
	// ----------------------------------------------------------------
	always_comb begin
		case (boot_code_r)
			2'h2: begin
				boot_base = ccp_pkg::DISC_A_BASE;
				boot_end = ccp_pkg::DISC_A_LAST;
			end
			2'h3: begin
				boot_base = ccp_pkg::DISC_B_BASE;
				boot_end = ccp_pkg::DISC_B_LAST;
			end
			default: begin
				boot_base = ccp_pkg::TAPE_BASE;
				boot_end = ccp_pkg::TAPE_LAST;
			end
		endcase
	end
	assign boot_last = boot_idx_r == boot_end;
	assign prom_addr = {boot_code_r, boot_idx_r};

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ccp_pkg::ST_IDLE;
			mem_bus <= '0;
			exec_req <= 1'b0;
			boot_idx_r <= 6'h00;
			boot_code_r <= 2'h0;
		end else begin
			case (state_r)
				ccp_pkg::ST_IDLE: begin
					if (press[ccp_pkg::SW_LOAD] && blink_wait_r && boot_ok) begin
						boot_code_r <= general_register_zero[1:0];
						boot_idx_r <= 6'h00;
						state_r <= ccp_pkg::ST_BOOT;
					end else if (manual_ok && view_r == ccp_pkg::VIEW_MEM &&
						press[ccp_pkg::SW_SHOW]) begin
						mem_bus <= '{req: 1'b1, we: 1'b0, addr: pc_r, wdata: 16'h0000};
						state_r <= ccp_pkg::ST_SHOW;
					end else if (manual_ok && view_r == ccp_pkg::VIEW_MEM &&
						press[ccp_pkg::SW_DEP]) begin
						mem_bus <= '{req: 1'b1, we: 1'b1, addr: pc_r, wdata: disp_r};
						state_r <= ccp_pkg::ST_DEP;
					end else if (!run_r && press[ccp_pkg::SW_START]) begin
						if (ir_r == 16'h0000) begin
							mem_bus <= '{req: 1'b1, we: 1'b0, addr: pc_r, wdata: 16'h0000};
							state_r <= ccp_pkg::ST_FETCH;
						end else begin
							exec_req <= 1'b1;
							state_r <= ccp_pkg::ST_EXEC;
						end
					end
				end
				ccp_pkg::ST_SHOW, ccp_pkg::ST_DEP, ccp_pkg::ST_FETCH: begin
					if (mem_ack) begin
						mem_bus <= '0;
						state_r <= ccp_pkg::ST_IDLE;
					end
				end
				ccp_pkg::ST_EXEC: begin
					if (exec_done) begin
						exec_req <= 1'b0;
						mem_bus <= '{req: 1'b1, we: 1'b0, addr: exec_next_pc, wdata: 16'h0000};
						state_r <= ccp_pkg::ST_FETCH;
					end
				end
				ccp_pkg::ST_BOOT: begin
					if (!mem_bus.req) begin
						mem_bus <= '{req: 1'b1, we: 1'b1, addr: boot_base + {10'h000, boot_idx_r},
							wdata: prom_rdata};
					end else if (mem_ack) begin
						mem_bus <= '0;
						boot_idx_r <= boot_idx_r + 6'h01;
						if (boot_last) begin
							state_r <= ccp_pkg::ST_IDLE;
						end
					end
				end
				default: state_r <= ccp_pkg::ST_IDLE;
			endcase
		end
	end
	assign exec_instr = ir_r;

	// Program counter: entry, auto increment, step result, loader entry point
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pc_r <= 16'h0000;
		end else if (state_r == ccp_pkg::ST_BOOT && mem_ack && mem_bus.req && boot_last) begin
			pc_r <= boot_base;
		end else if (mem_done && !(state_r == ccp_pkg::ST_BOOT)) begin
			pc_r <= mem_bus.addr + 16'h0001;
		end else if (entry_hit && view_r == ccp_pkg::VIEW_P) begin
			pc_r <= entered;
		end
	end

	// Instruction register: entry or fetched word
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ir_r <= 16'h0000;
		end else if (state_r == ccp_pkg::ST_FETCH && mem_ack) begin
			ir_r <= mem_rdata;
		end else if (entry_hit && view_r == ccp_pkg::VIEW_I) begin
			ir_r <= entered;
		end
	end

	// ----------------------------------------------------------------
	// Indicators
	// ----------------------------------------------------------------
	assign display_lamps = shown;
	assign sense_lamps = sense_r;
	assign view_lamps = view_r;
	assign sel_lamps = sel_r;
	assign run_lamp = run_r && (!blink_wait_r || blink_ph_r);
	assign step_lamp = !run_r;
	assign cpu_run = run_r && !blink_wait_r && state_r != ccp_pkg::ST_BOOT;
endmodule // ccp_panel

// file: bench/ccp_panel_assertions.sv
// Port checker for the console panel sequencer.
// Assumes one clock and the active-low power-on reset.
`timescale 1ns/1ps
module ccp_panel_chk (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic line_recovery,
	input wire logic overflow,
	input wire logic cpu_halted,
	input wire logic [2:0] flag_test,
	input wire logic flag_test_req,
	input wire logic flag_test_met,
	input wire logic [3:0] gr_sel,
	input wire logic gr_we,
	input wire ccp_pkg::ccp_mem_s mem_bus,
	input wire logic mem_ack,
	input wire logic exec_req,
	input wire logic exec_done,
	input wire logic cpu_run,
	input wire logic [15:0] display_lamps,
	input wire logic [2:0] sense_lamps,
	input wire logic [4:0] view_lamps,
	input wire logic step_lamp
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	a_flag_cond: assert property (flag_test_met == (flag_test_req && |(sense_lamps & flag_test)))
		else $error("flag test answer wrong");
	a_sense_one: assert property ($countones(sense_lamps ^ $past(sense_lamps)) <= 1)
		else $error("several sense flags moved at once");
	a_view_onehot: assert property ($onehot(view_lamps))
		else $error("view lamps not one-hot");
	// Overflow must have settled for two samples so a one-flop path still passes
	a_ovf_bit: assert property (step_lamp && view_lamps == ccp_pkg::VIEW_STAT
		&& $past(view_lamps) == ccp_pkg::VIEW_STAT && $stable(overflow)
		&& overflow == $past(overflow, 2) |-> display_lamps[ccp_pkg::STAT_OVF_BIT] == overflow)
		else $error("overflow lamp wrong");
	a_req_hold: assert property (mem_bus.req && !mem_ack |=> mem_bus.req && $stable(mem_bus.addr))
		else $error("memory request dropped early");
	a_req_drop: assert property (mem_bus.req && mem_ack |=> !mem_bus.req)
		else $error("memory request held after ack");
	a_run_quiet: assert property ($rose(mem_bus.req) && cpu_run |-> cpu_halted)
		else $error("memory access while running");
	a_gr_pulse: assert property (gr_we |-> (gr_sel != ccp_pkg::SEL_ZEROS
		&& gr_sel != ccp_pkg::SEL_ONES) ##1 !gr_we)
		else $error("register write bad");
	a_exec_hold: assert property (exec_req && !exec_done |=> exec_req)
		else $error("execute request dropped");
	// Start-up mode follows the recovery level once its synced copy lands
	a_run_step: assert property ($rose(reset_n) |-> ##3 (step_lamp == !line_recovery))
		else $error("start-up mode wrong");

	c_mem_write: cover property (mem_bus.req && mem_bus.we && mem_ack);
	c_exec: cover property (exec_req && exec_done);
	c_gr_write: cover property (gr_we);
endmodule // ccp_panel_chk

bind ccp_panel ccp_panel_chk u_chk (.clock(clock), .reset_n(reset_n), .overflow(overflow),
	.cpu_halted(cpu_halted), .flag_test(flag_test), .flag_test_req(flag_test_req),
	.flag_test_met(flag_test_met), .gr_sel(gr_sel), .gr_we(gr_we), .mem_bus(mem_bus),
	.mem_ack(mem_ack), .exec_req(exec_req), .exec_done(exec_done), .cpu_run(cpu_run),
	.display_lamps(display_lamps), .sense_lamps(sense_lamps), .view_lamps(view_lamps),
	.step_lamp(step_lamp), .line_recovery(line_recovery));

// file: bench/ccp_proc_model.sv
// Processor side model: memory, register file, PROM and executor.
// Assumes the panel's clock; memory answers promptly or late by address.
`timescale 1ns/1ps
module ccp_proc_model #(
	parameter logic [15:0] NEXT_PC = 16'h0040
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire ccp_pkg::ccp_mem_s mem_bus,
	output logic mem_ack,
	output logic [15:0] mem_rdata,
	input wire logic [3:0] gr_sel,
	input wire logic gr_we,
	input wire logic [15:0] gr_wdata,
	output logic [15:0] gr_rdata,
	output logic [15:0] reg_zero,
	input wire logic [7:0] prom_addr,
	output logic [15:0] prom_rdata,
	input wire logic exec_req,
	output logic exec_done,
	output logic [15:0] exec_next_pc
);
	logic [15:0] mem [0:1023];
	logic [15:0] regs [0:15];
	logic [1:0] wait_r;

	// Known contents so reads are distinguishable
	initial begin
		for (int i = 0; i < 1024; i++)
			mem[i] = 16'h1000 + 16'(i);
		for (int i = 0; i < 16; i++)
			regs[i] = 16'h0000;
	end

	// Odd addresses answer two cycles late; idle data toggles, never holds
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mem_ack <= 1'b0;
			wait_r <= 2'h0;
			mem_rdata <= 16'h0000;
		end else if (mem_bus.req && !mem_ack) begin
			if (wait_r == {mem_bus.addr[0], 1'b0}) begin
				mem_ack <= 1'b1;
				wait_r <= 2'h0;
				mem_rdata <= mem[mem_bus.addr[9:0]];
				if (mem_bus.we)
					mem[mem_bus.addr[9:0]] <= mem_bus.wdata;
			end else
				wait_r <= wait_r + 2'h1;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end

	// Register file and executor
	always @(posedge clock) begin
		if (gr_we)
			regs[gr_sel] <= gr_wdata;
		exec_done <= reset_n && exec_req && !exec_done;
	end
	assign gr_rdata = regs[gr_sel];
	assign reg_zero = regs[0];
	assign prom_rdata = {8'ha5, prom_addr};
	assign exec_next_pc = NEXT_PC;
endmodule // ccp_proc_model

// file: bench/test_ccp_panel.sv
// Self-checking bench for the console panel sequencer.
// Assumes short settle and blink counts; switches change at falling edges.
`timescale 1ns/1ps
module test_ccp_panel;
	localparam int E = ccp_pkg::SW_ENTRY;
	localparam int V = ccp_pkg::SW_VIEW;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [35:0] sw_v = '0;
	logic line_recovery = 1'b0;
	logic cpu_halted = 1'b0;
	logic overflow = 1'b0;
	logic [2:0] flag_test = 3'h0;
	logic flag_test_req = 1'b0;
	logic flag_test_met, gr_we, mem_ack, exec_req, exec_done, cpu_run, run_lamp, step_lamp;
	logic [3:0] gr_sel, sel_lamps;
	logic [15:0] gr_rdata, gr_wdata, mem_rdata, prom_rdata, exec_instr, exec_next_pc;
	logic [15:0] display_lamps, reg_zero;
	logic [7:0] prom_addr;
	logic [2:0] sense_lamps;
	logic [4:0] view_lamps;
	ccp_pkg::ccp_mem_s mem_bus;
	int error_cnt = 0;
	int samples_checked = 0;
	int ones;

	always #50 clock = ~clock;

	ccp_panel #(.SETTLE_CYCLES(4), .BLINK_CYCLES(8)) u_dut (
		.clock(clock), .reset_n(reset_n), .sense_sw(sw_v[2:0]), .entry_sw(sw_v[18:3]),
		.view_clear_switch(sw_v[19]), .show_switch(sw_v[20]), .deposit_sw(sw_v[21]),
		.start_sw(sw_v[22]), .load_sw(sw_v[23]), .step_run_sw(sw_v[24]),
		.view_sw(sw_v[29:25]), .sel_set_sw(sw_v[33:30]), .sel_clear_sw(sw_v[34]),
		.sel_incr_sw(sw_v[35]), .line_recovery(line_recovery), .cpu_halted(cpu_halted),
		.status_in(16'h0000), .overflow(overflow), .flag_test(flag_test),
		.flag_test_req(flag_test_req), .flag_test_met(flag_test_met),
		.general_register_zero(reg_zero), .gr_sel(gr_sel), .gr_rdata(gr_rdata),
		.gr_we(gr_we), .gr_wdata(gr_wdata), .mem_bus(mem_bus), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .prom_addr(prom_addr), .prom_rdata(prom_rdata),
		.exec_req(exec_req), .exec_instr(exec_instr), .exec_done(exec_done),
		.exec_next_pc(exec_next_pc), .cpu_run(cpu_run), .display_lamps(display_lamps),
		.sense_lamps(sense_lamps), .view_lamps(view_lamps), .sel_lamps(sel_lamps),
		.run_lamp(run_lamp), .step_lamp(step_lamp)
	);

	ccp_proc_model u_proc (
		.clock(clock), .reset_n(reset_n), .mem_bus(mem_bus), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .gr_sel(gr_sel), .gr_we(gr_we), .gr_wdata(gr_wdata),
		.gr_rdata(gr_rdata), .reg_zero(reg_zero), .prom_addr(prom_addr),
		.prom_rdata(prom_rdata), .exec_req(exec_req), .exec_done(exec_done),
		.exec_next_pc(exec_next_pc)
	);

	// ----
	// Tasks
	// ----
	// Hold and release long enough for the debouncer both ways
	task automatic press(input int idx);
		@(negedge clock);
		sw_v[idx] = 1'b1;
		repeat (12) @(negedge clock);
		sw_v[idx] = 1'b0;
		repeat (12) @(negedge clock);
	endtask

	task automatic chk(input logic [15:0] exp, input logic [15:0] got, input string nm);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog, about thirty times the expected run
	initial begin
		#3000000;
		error_cnt++;
		final_report();
	end

	// ----
	// Tests
	// ----
	initial begin
		repeat (3) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
		chk(16'h0010, {11'h0, step_lamp, run_lamp, sense_lamps}, "power lamps");
		chk({11'h0, ccp_pkg::VIEW_P}, {11'h0, view_lamps}, "power view");
		chk(16'h0000, display_lamps, "power display");
		chk(16'h0000, {12'h0, sel_lamps}, "power select");
		// Sense flag, flag test and a short glitch
		press(1);
		chk(16'h0002, {13'h0, sense_lamps}, "sense set");
		flag_test = 3'h2;
		flag_test_req = 1'b1;
		#1 chk(16'h0001, {15'h0, flag_test_met}, "flag met");
		flag_test = 3'h5;
		#1 chk(16'h0000, {15'h0, flag_test_met}, "flag unmet");
		flag_test_req = 1'b0;
		@(negedge clock);
		sw_v[0] = 1'b1;
		repeat (2) @(negedge clock);
		sw_v[0] = 1'b0;
		repeat (12) @(negedge clock);
		chk(16'h0002, {13'h0, sense_lamps}, "sense glitch");
		press(1);
		chk(16'h0000, {13'h0, sense_lamps}, "sense clear");
		// Program counter entry, repeat bit has no effect
		press(E + 4);
		chk(16'h0010, display_lamps, "pc entry");
		press(E + 4);
		chk(16'h0010, display_lamps, "pc repeat");
		// Deposit at 0x10, then show 0x11 (late answer)
		press(V + 2);
		press(ccp_pkg::SW_VCLR);
		press(E + 0);
		chk(16'h0001, display_lamps, "display compose");
		press(ccp_pkg::SW_DEP);
		chk(16'h0001, u_proc.mem[16], "deposit word");
		press(ccp_pkg::SW_SHOW);
		chk(16'h1011, display_lamps, "show word");
		press(V + 0);
		chk(16'h0012, display_lamps, "pc after two");
		// Stepping from a cleared instruction register
		press(V + 1);
		press(ccp_pkg::SW_VCLR);
		chk(16'h0000, display_lamps, "ir cleared");
		press(ccp_pkg::SW_START);
		chk(16'h1012, display_lamps, "first fetch");
		press(ccp_pkg::SW_START);
		chk(16'h1040, display_lamps, "exec then fetch");
		chk(16'h1040, exec_instr, "next instruction");
		// Overflow on the status view
		press(V + 3);
		overflow = 1'b1;
		repeat (4) @(negedge clock);
		chk(16'h0001, {15'h0, display_lamps[8]}, "overflow on");
		overflow = 1'b0;
		repeat (4) @(negedge clock);
		chk(16'h0000, {15'h0, display_lamps[8]}, "overflow off");
		// Select code bit and step, then loader code 2 into general register zero
		press(V + 4);
		press(ccp_pkg::SW_FSET + 1);
		press(ccp_pkg::SW_FINC);
		chk(16'h0003, {12'h0, sel_lamps}, "select step");
		press(ccp_pkg::SW_FCLR);
		press(ccp_pkg::SW_VCLR);
		press(E + 1);
		chk(16'h0002, u_proc.regs[0], "register zero");
		chk(16'h0002, display_lamps, "register view");
		// Run mode: blinking, manual deposit refused
		press(ccp_pkg::SW_MODE);
		ones = 0;
		repeat (32) begin
			@(negedge clock);
			ones += int'(run_lamp);
		end
		chk(16'h0010, 16'(ones), "blink count");
		press(V + 2);
		press(ccp_pkg::SW_DEP);
		chk(16'h1041, u_proc.mem[65], "run deposit");
		// Boot copies the second loader image
		press(ccp_pkg::SW_LOAD);
		for (int i = 0; i < 500 && cpu_run !== 1'b1; i++)
			@(negedge clock);
		chk(16'h0001, {15'h0, cpu_run}, "boot run");
		chk(16'ha580, u_proc.mem[600], "loader first");
		chk(16'ha59f, u_proc.mem[631], "loader last");
		ones = 0;
		repeat (32) begin
			@(negedge clock);
			ones += int'(run_lamp);
		end
		chk(16'h0020, 16'(ones), "run steady");
		// Halted processor admits a show; pc sits at the loader base
		cpu_halted = 1'b1;
		press(ccp_pkg::SW_SHOW);
		chk(16'ha580, display_lamps, "halted show");
		cpu_halted = 1'b0;
		// A set flag must not survive the recovery start
		press(0);
		// Line power recovery
		reset_n = 1'b0;
		line_recovery = 1'b1;
		repeat (3) @(negedge clock);
		reset_n = 1'b1;
		repeat (6) @(negedge clock);
		chk(16'h0008, {11'h0, step_lamp, run_lamp, sense_lamps}, "recovery lamps");
		chk({11'h0, ccp_pkg::VIEW_P}, {11'h0, view_lamps}, "recovery view");
		final_report();
	end
endmodule // test_ccp_panel
